// File: iod_pkg.sv
// Package for the I/O space access decoder
`default_nettype none
package iod_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam logic [15:0] IO_DS_OFFSET  = 16'h0020;
    localparam logic [15:0] EXT_DS_LO     = 16'h0060;
    localparam logic [15:0] EXT_DS_HI     = 16'h01ff;
    localparam logic [5:0]  IO_LAST       = 6'h3f;
    localparam logic [5:0]  BIT_IO_LAST   = 6'h1f;
    localparam int          IO_LOCATIONS  = 64;
    localparam logic [5:0]  GPR0_IO       = 6'h1e;
    localparam logic [5:0]  GPR1_IO       = 6'h2a;
    localparam logic [5:0]  GPR2_IO       = 6'h2b;
    localparam logic [5:0]  FLAG_IO       = 6'h16;
    localparam logic [7:0]  GPR_RST       = 8'h00;
    localparam logic [7:0]  FLAG_RST      = 8'h00;

    typedef enum logic [2:0]
    {
        IOD_OP_NONE,
        IOD_OP_IN,
        IOD_OP_OUT,
        IOD_OP_LOAD,
        IOD_OP_STORE,
        IOD_OP_SET_BIT,
        IOD_OP_CLR_BIT,
        IOD_OP_TEST_BIT
    } iod_op_t;

    typedef enum logic [1:0]
    {
        IOD_TGT_WREG,
        IOD_TGT_IO,
        IOD_TGT_EXT,
        IOD_TGT_NONE
    } iod_tgt_t;
endpackage
`default_nettype wire

// File: iod_decode.sv
// Address decoder from operation and address to target and I/O location
`default_nettype none
module iod_decode
(
    input  wire iod_pkg::iod_op_t    op,
    input  wire logic [15:0]         addr,
    output iod_pkg::iod_tgt_t        tgt,
    output logic [5:0]               io_loc,
    output logic [8:0]               ext_off,
    output logic                     bit_ok
);
    import iod_pkg::*;

    logic [15:0] io_rel;

    always_comb
    begin
        io_rel  = addr - IO_DS_OFFSET;
        tgt     = IOD_TGT_NONE;
        io_loc  = 6'h00;
        ext_off = 9'h000;
        bit_ok  = 1'b0;
        unique case (op)
            IOD_OP_IN, IOD_OP_OUT:
            begin
                // Opcode field is six bits, so only 64 locations exist
                io_loc = addr[5:0];
                tgt    = (addr[15:6] == 10'h000) ? IOD_TGT_IO : IOD_TGT_NONE;
            end
            IOD_OP_SET_BIT, IOD_OP_CLR_BIT, IOD_OP_TEST_BIT:
            begin
                io_loc = addr[5:0];
                bit_ok = (addr[15:5] == 11'h000);
                tgt    = bit_ok ? IOD_TGT_IO : IOD_TGT_NONE;
            end
            IOD_OP_LOAD, IOD_OP_STORE:
            begin
                if (addr < IO_DS_OFFSET)
                    tgt = IOD_TGT_WREG;
                else if (addr < EXT_DS_LO)
                begin
                    tgt    = IOD_TGT_IO;
                    io_loc = io_rel[5:0];
                end
                else if (addr <= EXT_DS_HI)
                begin
                    tgt     = IOD_TGT_EXT;
                    ext_off = addr[8:0];
                end
            end
            default:
                tgt = IOD_TGT_NONE;
        endcase
    end
endmodule
`default_nettype wire

// File: iod_io_space.sv
// I/O space access decode with scratch registers and write-one-to-clear flags
`default_nettype none
// Operation
// - All I/O locations readable and writable by data-space load and store.
// - Bit set, clear and test only for I/O locations 0x00 to 0x1F.
// - I/O in and out instructions use I/O addresses 0x00 to 0x3F.
// - Data-space address of an I/O register is its I/O address plus 0x20.
// - I/O in and out instructions reach only 64 locations.
// - Extended range 0x60 to 0x1FF reached only by load and store.
// - Status flags clear on writing one; writing zero leaves them.
// - Bit set and clear touch only the addressed bit.
// - Three scratch registers; the low one supports bit operations.
module iod_io_space
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire iod_pkg::iod_op_t   op,
    input  wire logic [15:0]        addr,
    input  wire logic [2:0]         bit_sel,
    input  wire logic [7:0]         wdata,
    input  wire logic [7:0]         flag_set,
    input  wire logic [7:0]         periph_rdata,
    input  wire logic [7:0]         ext_rdata,
    output logic                    io_sel_r,
    output logic                    io_we_r,
    output logic [5:0]              io_loc_r,
    output logic                    ext_sel_r,
    output logic                    ext_we_r,
    output logic [8:0]              ext_off_r,
    output logic                    wreg_sel_r,
    output logic [4:0]              wreg_idx_r,
    output logic [7:0]              wdata_r,
    output logic [7:0]              rdata_r,
    output logic                    skip_r,
    output logic                    refused_r,
    output logic [7:0]              flags_r,
    output logic [7:0]              gpr0_r,
    output logic [7:0]              gpr1_r,
    output logic [7:0]              gpr2_r
);
    import iod_pkg::*;

    iod_tgt_t    tgt;
    logic [5:0]  io_loc;
    logic [8:0]  ext_off;
    logic        bit_ok;
    logic [7:0]  io_cur;
    logic [7:0]  bit_mask;
    logic        is_write;
    logic        is_read;

    iod_decode u_decode
    (
        .op      (op),
        .addr    (addr),
        .tgt     (tgt),
        .io_loc  (io_loc),
        .ext_off (ext_off),
        .bit_ok  (bit_ok)
    );

    // ----------------------------------------
    // Local I/O read mux
    // ----------------------------------------
    function automatic logic [7:0] io_read
    (
        input logic [5:0] loc,
        input logic [7:0] g0,
        input logic [7:0] g1,
        input logic [7:0] g2,
        input logic [7:0] fl,
        input logic [7:0] per
    );
        logic [7:0] v;
        v = per;
        if (loc == GPR0_IO)
            v = g0;
        else if (loc == GPR1_IO)
            v = g1;
        else if (loc == GPR2_IO)
            v = g2;
        else if (loc == FLAG_IO)
            v = fl;
        return v;
    endfunction

    always_comb
    begin
        io_cur   = io_read(io_loc, gpr0_r, gpr1_r, gpr2_r, flags_r, periph_rdata);
        bit_mask = 8'h01 << bit_sel;
        is_write = (op == IOD_OP_OUT) || (op == IOD_OP_STORE);
        is_read  = (op == IOD_OP_IN) || (op == IOD_OP_LOAD);
    end

    // ----------------------------------------
    // Scratch registers
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            gpr0_r <= GPR_RST;
            gpr1_r <= GPR_RST;
            gpr2_r <= GPR_RST;
        end
        else if (tgt == IOD_TGT_IO)
        begin
            if (is_write)
            begin
                if (io_loc == GPR0_IO)
                    gpr0_r <= wdata;
                if (io_loc == GPR1_IO)
                    gpr1_r <= wdata;
                if (io_loc == GPR2_IO)
                    gpr2_r <= wdata;
            end
            else if (io_loc == GPR0_IO && op == IOD_OP_SET_BIT)
                gpr0_r <= gpr0_r | bit_mask;
            else if (io_loc == GPR0_IO && op == IOD_OP_CLR_BIT)
                gpr0_r <= gpr0_r & ~bit_mask;
        end
    end

    // ----------------------------------------
    // Status flags, write one to clear
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            flags_r <= FLAG_RST;
        else
        begin
            // Set wins over clear so no event is lost
            if (tgt == IOD_TGT_IO && io_loc == FLAG_IO && is_write)
                flags_r <= (flags_r & ~wdata) | flag_set;
            else if (tgt == IOD_TGT_IO && io_loc == FLAG_IO && op == IOD_OP_SET_BIT)
                flags_r <= (flags_r & ~bit_mask) | flag_set;
            else
                flags_r <= flags_r | flag_set;
        end
    end

    // ----------------------------------------
    // Access strobes toward peripherals
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            io_sel_r   <= 1'b0;
            io_we_r    <= 1'b0;
            io_loc_r   <= 6'h00;
            ext_sel_r  <= 1'b0;
            ext_we_r   <= 1'b0;
            ext_off_r  <= 9'h000;
            wreg_sel_r <= 1'b0;
            wreg_idx_r <= 5'h00;
            wdata_r    <= 8'h00;
            refused_r  <= 1'b0;
        end
        else
        begin
            // Peripheral write strobe only for plain writes; bit ops stay local
            io_sel_r   <= (tgt == IOD_TGT_IO) && (is_read || is_write);
            io_we_r    <= (tgt == IOD_TGT_IO) && is_write;
            io_loc_r   <= io_loc;
            ext_sel_r  <= (tgt == IOD_TGT_EXT);
            ext_we_r   <= (tgt == IOD_TGT_EXT) && (op == IOD_OP_STORE);
            ext_off_r  <= ext_off;
            wreg_sel_r <= (tgt == IOD_TGT_WREG);
            wreg_idx_r <= addr[4:0];
            wdata_r    <= wdata;
            refused_r  <= (op != IOD_OP_NONE) && (tgt == IOD_TGT_NONE);
        end
    end

    // ----------------------------------------
    // Read data and skip result
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_r <= 8'h00;
            skip_r  <= 1'b0;
        end
        else
        begin
            if (tgt == IOD_TGT_EXT)
                rdata_r <= ext_rdata;
            else if (tgt == IOD_TGT_IO && is_read)
                rdata_r <= io_cur;
            skip_r <= (op == IOD_OP_TEST_BIT) && bit_ok
                      && (io_cur[bit_sel] == wdata[0]);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    bit_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_SET_BIT && addr[15:5] != 11'h000) |=> !io_sel_r && refused_r)
        else $error("bit op above 0x1f accepted");
    io_offset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_LOAD && addr >= 16'h0020 && addr < 16'h0060)
        |=> io_sel_r && io_loc_r == $past(addr[5:0]) - 6'h20)
        else $error("load to io space mis-mapped");
    in_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_IN && addr > 16'h003f) |=> refused_r && !io_sel_r)
        else $error("io in beyond 64 locations");
    ext_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_OUT) |=> !ext_sel_r)
        else $error("io out reached extended space");
    ext_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_STORE && addr >= 16'h0060 && addr <= 16'h01ff) |=> ext_sel_r && ext_we_r)
        else $error("store to extended space lost");
    flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_OUT && addr[15:0] == 16'h0016 && flag_set == 8'h00)
        |=> flags_r == ($past(flags_r) & ~$past(wdata)))
        else $error("flag write one clear wrong");
    flag_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(flags_r[0]) |-> $past(flag_set[0]))
        else $error("flag set without event");
    bit_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_SET_BIT && addr == 16'h001e)
        |=> ((gpr0_r ^ $past(gpr0_r)) & ~$past(bit_mask)) == 8'h00 && (gpr0_r & $past(bit_mask)) != 8'h00)
        else $error("bit set touched other bits");
    gpr_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_STORE && addr == 16'h004a) |=> gpr1_r == $past(wdata))
        else $error("scratch register store lost");
    wreg_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (op == IOD_OP_LOAD && addr < 16'h0020) |=> wreg_sel_r && !io_sel_r)
        else $error("low address not working register");
endmodule
`default_nettype wire

// File: iod_periph_model.sv
// Peripheral and extended space read model for the I/O space decoder
`default_nettype none
module iod_periph_model
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire iod_pkg::iod_op_t  op,
    input  wire logic [15:0]       addr,
    output logic [7:0]             periph_rdata,
    output logic [7:0]             ext_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import iod_pkg::*;
    logic [7:0] junk_r;
    logic       io_hit;
    logic       ext_hit;
    logic [5:0] loc;
    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Unselected reads toggle, so a stale value is never taken for real data
    always_ff @(posedge ref_clk)
        junk_r <= rst_n ? ~junk_r : 8'h5a;
    always_comb
    begin
        io_hit  = 1'b0;
        loc     = addr[5:0];
        ext_hit = (op == IOD_OP_LOAD || op == IOD_OP_STORE) && addr >= EXT_DS_LO
                  && addr <= EXT_DS_HI;
        if ((op == IOD_OP_IN || op == IOD_OP_OUT) && addr <= 16'h003f)
            io_hit = 1'b1;
        else if ((op == IOD_OP_LOAD || op == IOD_OP_STORE) && addr >= IO_DS_OFFSET
                 && addr < EXT_DS_LO)
        begin
            io_hit = 1'b1;
            loc    = 6'(addr - IO_DS_OFFSET);
        end
        periph_rdata = io_hit ? {2'h2, loc} : junk_r;
        ext_rdata    = ext_hit ? (addr[7:0] ^ 8'h3c) : junk_r;
    end
endmodule
`default_nettype wire

// File: io_space_access_decode_test.sv
// Self-checking bench for the I/O space decoder
`default_nettype none
module io_space_access_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    import iod_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    iod_op_t op = IOD_OP_NONE;
    logic [15:0] addr = 16'h0;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] wdata = 8'h0, flag_set = 8'h0, periph_rdata, ext_rdata;
    logic io_sel_r, io_we_r, ext_sel_r, ext_we_r, wreg_sel_r, skip_r, refused_r;
    logic [5:0] io_loc_r;
    logic [8:0] ext_off_r;
    logic [4:0] wreg_idx_r;
    logic [7:0] wdata_r, rdata_r, flags_r, gpr0_r, gpr1_r, gpr2_r, d, g0;
    logic [5:0] loc;
    logic [15:0] a;
    int err_count = 0, cmp_count = 0, seed = 32'h3963b893;
    iod_op_t bad_op [7] = '{IOD_OP_IN, IOD_OP_OUT, IOD_OP_SET_BIT, IOD_OP_CLR_BIT,
                            IOD_OP_TEST_BIT, IOD_OP_LOAD, IOD_OP_STORE};
    logic [15:0] bad_a [7] = '{16'h40, 16'h40, 16'h20, 16'h3f, 16'h20, 16'h200, 16'h200};
    always #10 ref_clk = ~ref_clk;
    iod_io_space u_iod_io_space (.ref_clk(ref_clk), .rst_n(rst_n), .op(op), .addr(addr),
        .bit_sel(bit_sel), .wdata(wdata), .flag_set(flag_set), .periph_rdata(periph_rdata),
        .ext_rdata(ext_rdata), .io_sel_r(io_sel_r), .io_we_r(io_we_r), .io_loc_r(io_loc_r),
        .ext_sel_r(ext_sel_r), .ext_we_r(ext_we_r), .ext_off_r(ext_off_r),
        .wreg_sel_r(wreg_sel_r), .wreg_idx_r(wreg_idx_r), .wdata_r(wdata_r),
        .rdata_r(rdata_r), .skip_r(skip_r), .refused_r(refused_r), .flags_r(flags_r),
        .gpr0_r(gpr0_r), .gpr1_r(gpr1_r), .gpr2_r(gpr2_r));
    iod_periph_model u_iod_periph_model (.ref_clk(ref_clk), .rst_n(rst_n), .op(op),
        .addr(addr), .periph_rdata(periph_rdata), .ext_rdata(ext_rdata));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] exp_periph(input logic [5:0] l);
        return {2'h2, l};
    endfunction
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    // One access; result is checked one cycle later while strobes stand
    task automatic issue(input iod_op_t o, input logic [15:0] ad, input logic [2:0] b,
                         input logic [7:0] wd);
        @(posedge ref_clk);
        #1;
        op      = o;
        addr    = ad;
        bit_sel = b;
        wdata   = wd;
        @(posedge ref_clk);
        #1;
        op = IOD_OP_NONE;
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard; no wait in the sequence is open-ended
    initial
    begin
        #200us;
        err_count++;
        finish_test();
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk("rst_state", 16'h0, {gpr0_r, flags_r} | rdata_r | io_sel_r);
        d = 8'($random(seed));
        issue(IOD_OP_STORE, 16'h3e, 3'h0, d);
        chk("st_loc", {1'b1, 1'b1, 6'h1e}, {io_sel_r, io_we_r, io_loc_r});
        chk("st_gpr0", d, gpr0_r);
        g0 = d;
        d = 8'($random(seed));
        issue(IOD_OP_OUT, {10'h0, GPR1_IO}, 3'h0, d);
        issue(IOD_OP_LOAD, 16'h4a, 3'h0, 8'h0);
        chk("ld_gpr1", d, rdata_r);
        issue(IOD_OP_STORE, 16'h4b, 3'h0, ~d);
        issue(IOD_OP_IN, {10'h0, GPR2_IO}, 3'h0, 8'h0);
        // Inversion kept inside a concat so it stays eight bits wide
        chk("in_gpr2", {8'h0, ~d}, rdata_r);
        chk("gpr1_gpr2", {d, ~d}, {gpr1_r, gpr2_r});
        for (int i = 0; i < 8; i++)
        begin
            loc = (i == 0) ? 6'h3f : 6'($random(seed));
            if (loc inside {GPR0_IO, GPR1_IO, GPR2_IO, FLAG_IO})
                loc = 6'h05;
            issue(IOD_OP_IN, {10'h0, loc}, 3'h0, 8'h0);
            chk("in_rd", {1'b0, loc, exp_periph(loc)},
                {refused_r, io_loc_r, rdata_r});
            issue(IOD_OP_LOAD, {10'h0, loc} + IO_DS_OFFSET, 3'h0, 8'h0);
            chk("ld_rd", {1'b1, loc, exp_periph(loc)},
                {io_sel_r, io_loc_r, rdata_r});
        end
        for (int i = 0; i < 7; i++)
        begin
            issue(bad_op[i], bad_a[i], 3'h0, 8'hff);
            chk("refuse", 16'h4, {refused_r, io_sel_r, ext_sel_r});
            chk("refuse_keep", {g0, exp_periph(loc)}, {gpr0_r, rdata_r});
        end
        for (int i = 0; i < 12; i++)
        begin
            d = 8'($random(seed));
            issue(d[7] ? IOD_OP_SET_BIT : IOD_OP_CLR_BIT, {10'h0, GPR0_IO}, d[2:0], 8'h0);
            g0[d[2:0]] = d[7];
            chk("bit_op", {1'b0, g0}, {io_sel_r, gpr0_r});
            issue(IOD_OP_TEST_BIT, {10'h0, GPR0_IO}, d[5:3], {7'h0, d[6]});
            chk("bit_test", 16'(g0[d[5:3]] == d[6]), 16'(skip_r));
        end
        @(posedge ref_clk);
        #1;
        flag_set = 8'hff;
        @(posedge ref_clk);
        #1;
        flag_set = 8'h0;
        chk("flag_set", 16'hff, flags_r);
        issue(IOD_OP_STORE, 16'h36, 3'h0, 8'h0f);
        chk("flag_w1c", 16'hf0, flags_r);
        issue(IOD_OP_SET_BIT, {10'h0, FLAG_IO}, 3'h7, 8'h0);
        issue(IOD_OP_CLR_BIT, {10'h0, FLAG_IO}, 3'h6, 8'h0);
        issue(IOD_OP_LOAD, 16'h36, 3'h0, 8'h0);
        chk("flag_bit", 16'h7070, {flags_r, rdata_r});
        issue(IOD_OP_OUT, {10'h0, FLAG_IO}, 3'h0, 8'h10);
        chk("flag_out", 16'h60, flags_r);
        // Event and clear in one cycle: the event must survive
        @(posedge ref_clk);
        #1;
        op       = IOD_OP_OUT;
        addr     = {10'h0, FLAG_IO};
        wdata    = 8'h21;
        flag_set = 8'h01;
        @(posedge ref_clk);
        #1;
        op       = IOD_OP_NONE;
        flag_set = 8'h0;
        chk("flag_race", 16'h41, flags_r);
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? EXT_DS_LO : (i == 1) ? EXT_DS_HI
                : 16'h60 + 16'($random(seed)) % 16'h1a0;
            issue(IOD_OP_LOAD, a, 3'h0, 8'h0);
            chk("ext_ld", {3'h4, 5'h0, a[7:0] ^ 8'h3c},
                {ext_sel_r, ext_we_r, io_sel_r, 5'h0, rdata_r});
            chk("ext_off", a, 16'(ext_off_r));
            d = 8'($random(seed));
            issue(IOD_OP_STORE, a, 3'h0, d);
            chk("ext_st", {2'h3, d}, {ext_sel_r, ext_we_r, wdata_r});
            a = 16'($random(seed)) & 16'h1f;
            issue(IOD_OP_LOAD, a, 3'h0, 8'h0);
            chk("wreg", {2'h2, a[4:0]}, {wreg_sel_r, io_sel_r, wreg_idx_r});
        end
        // Second reset in mid-run must clear all state again
        @(posedge ref_clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk("rst2_gpr", 16'h0, {gpr1_r, gpr2_r});
        chk("rst2_flag", 16'h0, {gpr0_r, flags_r});
        issue(IOD_OP_STORE, 16'h4b, 3'h0, 8'ha5);
        chk("rst2_store", 16'ha5, gpr2_r);
        finish_test();
    end
endmodule
`default_nettype wire
